// ==== rtl/mrdb_pkg.sv ====
/*
 package for the micro memory, delta translator and bit test block.
 assumes a single 125 MHz clock shared with the host micro-sequencer.
*/
package mrdb_pkg;
  // ==========================================================
  // register map (byte addresses, axi4-lite, 32-bit words)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_ROM_ADDR = 8'h08;
  localparam logic [7:0] ADDR_ROM_LO = 8'h0c;
  localparam logic [7:0] ADDR_ROM_HI = 8'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ctrl fields
  localparam int CTRL_SEQ_EN_BIT = 0;
  localparam int CTRL_KICK_BIT = 1;
  localparam logic CTRL_SEQ_EN_RST = 1'h1;
  // ==========================================================
  // macro instruction fields (i00 is the msb)
  localparam int OPC_HI = 15;
  localparam int OPC_LO = 12;
  localparam int SUBOP_HI = 11;
  localparam int SUBOP_LO = 8;
  localparam int DELTA_HI = 7;
  localparam logic [3:0] OPC_ZERO = 4'h0;
  localparam logic [3:0] SUBOP_INTER_REG = 4'h8;
  localparam logic [15:0] DELTA_ALL_ONES = 16'hffff;
  // ==========================================================
  // micro memory geometry
  localparam int ROM_WORDS = 512;
  localparam int ROM_WIDTH = 64;
  localparam int UINSTR_WIDTH = 32;
  localparam int PAGE_WORDS = 256;
  localparam logic [8:0] DECODE_LOC_A = 9'h058;
  localparam logic [8:0] DECODE_LOC_B = 9'h059;
  // arbitrary micro instruction codes for the decode routine
  localparam logic [31:0] UI_INCREMENT = 32'h0000_1001;
  localparam logic [31:0] UI_READ_NEXT = 32'h0000_2002;
  localparam logic [31:0] UI_INT_BRANCH = 32'h0000_3003;
  localparam logic [31:0] UI_FETCH_XFORM = 32'h0000_4004;
  // ==========================================================
  // bit test
  localparam logic [3:0] TEST_BIT_CMD = 4'h5;
  localparam int BT_SEL_HI = 3;
  // ==========================================================
  // decode-next-instruction sequencer
  typedef enum logic [2:0] {
    MRDB_SEQ_IDLE = 3'b000,
    MRDB_SEQ_INC = 3'b001,
    MRDB_SEQ_READ = 3'b010,
    MRDB_SEQ_XFORM = 3'b011,
    MRDB_SEQ_INTR = 3'b100
  } mrdb_seq_t;
endpackage

// ==== rtl/mrdb_top.sv ====
/*
 micro memory, delta translator and bit test selector for an emulator module.
 assumes the host sequencer, its selectors and x register run on aclk; only
 the two panel switches arrive asynchronously.
*/
// Chosen here: the address map and the AXI4-Lite slave port.
// What this block does
// - translator active only non-decimal, route clear, non-inter-register
// - inter-register instruction with route flag clear sends all-ones delta to selectors
// - route flag clear selects delta, set selects file
// - read-only micro memory, 512 words of 64 bits
// - each word holds upper and lower 32-bit instructions
// - eight address bits plus one page bit select
// - upper/lower selector drives chosen instruction onto x bus
// - decode routine lives at micro locations 058, 059
// - increment, read, check interrupt, else fetch transform
// - positions 1,2,3,13 upper on instr bits 02,07,06,00
// - position 4 upper when index store status true
// - positions 5,8 lower on protect fault, parity error
// - positions 6,7 lower on halt, pass switches
// - position 10 upper when delta field is zero
// - position 11 lower when address equals operand
// - position 12 upper on even parity line
// - position 14 upper on multilevel indirect mode
// - position 15 upper when previous write aborted
// - every emulation end jumps into decode routine
// - low four instruction-register bits pick, with test command
module mrdb_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  // axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // delta translator
  input wire logic [15:0] macro_instr,
  input wire logic [15:0] file_subop_data,
  input wire logic decimal_correction_flag,
  input wire logic file_route_flag,
  output logic [15:0] selector_delta_ff,
  // micro memory read
  input wire logic micro_read_req,
  input wire logic [7:0] micro_word_addr,
  input wire logic micro_page_select,
  input wire logic micro_upper_sel,
  output logic [31:0] x_bus_data_ff,
  output logic x_bus_oe_n_ff,
  // bit test
  input wire logic [31:0] micro_instr_reg,
  input wire logic [3:0] test_field,
  input wire logic index_store_status,
  input wire logic protect_fault_flag,
  input wire logic parity_error_flag,
  input wire logic selective_halt_switch,
  input wire logic selective_pass_switch,
  input wire logic eff_addr_matches_operand,
  input wire logic even_parity_line,
  input wire logic multilevel_indirect_mode,
  output logic bit_test_upper_ff,
  // decode-next-instruction sequencing
  input wire logic emulation_done,
  input wire logic interrupt_pending,
  output logic [8:0] decode_entry_addr_ff,
  output logic increment_next_instr,
  output logic read_next_instr,
  output logic macro_fetch_transform,
  output logic interrupt_branch
);
  // ========================================================
  // micro memory contents
  // the store is constant; only the decode routine words are fixed here,
  // the rest hold an address-derived filler pattern
  function automatic logic [63:0] rom_word(input logic [8:0] a);
    logic [63:0] w;
    w = {7'h00, a, 7'h00, a, 7'h00, a, 7'h00, a};
    if (a == mrdb_pkg::DECODE_LOC_A) begin
      w = {mrdb_pkg::UI_INCREMENT, mrdb_pkg::UI_READ_NEXT};
    end else if (a == mrdb_pkg::DECODE_LOC_B) begin
      w = {mrdb_pkg::UI_INT_BRANCH, mrdb_pkg::UI_FETCH_XFORM};
    end
    return w;
  endfunction
  // ========================================================
  // register bus slave
  logic ctrl_seq_en_ff;
  logic kick_ff;
  logic [8:0] rom_addr_ff;
  logic aw_hold_ff;
  logic w_hold_ff;
  logic [7:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic [63:0] sw_rom_word;
  mrdb_pkg::mrdb_seq_t seq_ff;
  logic [31:0] status_word;
  logic [31:0] nxt_rdata;
  logic [1:0] nxt_rresp;
  logic wr_fire;
  assign awready = !aw_hold_ff && !bvalid;
  assign wready = !w_hold_ff && !bvalid;
  assign arready = !rvalid;
  assign wr_fire = aw_hold_ff && w_hold_ff && !bvalid;
  assign sw_rom_word = rom_word(rom_addr_ff);
  assign status_word = {20'h00000, bit_test_upper_ff, x_bus_oe_n_ff,
                        ctrl_seq_en_ff, 6'h00, seq_ff};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
    end else if (awvalid && awready) begin
      aw_hold_ff <= 1'b1;
      aw_addr_ff <= awaddr;
    end else if (wr_fire) begin
      aw_hold_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_ff <= 1'b0;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
    end else if (wvalid && wready) begin
      w_hold_ff <= 1'b1;
      w_data_ff <= wdata;
      w_strb_ff <= wstrb;
    end else if (wr_fire) begin
      w_hold_ff <= 1'b0;
    end
  end

  // control writes; the kick bit is a one-cycle strobe, never stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_seq_en_ff <= mrdb_pkg::CTRL_SEQ_EN_RST;
      kick_ff <= 1'b0;
      rom_addr_ff <= 9'h000;
    end else begin
      kick_ff <= 1'b0;
      if (wr_fire && aw_addr_ff == mrdb_pkg::ADDR_CTRL && w_strb_ff[0]) begin
        ctrl_seq_en_ff <= w_data_ff[mrdb_pkg::CTRL_SEQ_EN_BIT];
        kick_ff <= w_data_ff[mrdb_pkg::CTRL_KICK_BIT];
      end
      if (wr_fire && aw_addr_ff == mrdb_pkg::ADDR_ROM_ADDR) begin
        if (w_strb_ff[0]) begin
          rom_addr_ff[7:0] <= w_data_ff[7:0];
        end
        if (w_strb_ff[1]) begin
          rom_addr_ff[8] <= w_data_ff[8];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= mrdb_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp <= (aw_addr_ff == mrdb_pkg::ADDR_CTRL ||
                aw_addr_ff == mrdb_pkg::ADDR_ROM_ADDR) ?
               mrdb_pkg::RESP_OKAY : mrdb_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_comb begin
    nxt_rresp = mrdb_pkg::RESP_OKAY;
    unique case (araddr)
      mrdb_pkg::ADDR_CTRL: nxt_rdata = {31'h0000_0000, ctrl_seq_en_ff};
      mrdb_pkg::ADDR_STATUS: nxt_rdata = status_word;
      mrdb_pkg::ADDR_ROM_ADDR: nxt_rdata = {23'h000000, rom_addr_ff};
      mrdb_pkg::ADDR_ROM_LO: nxt_rdata = sw_rom_word[31:0];
      mrdb_pkg::ADDR_ROM_HI: nxt_rdata = sw_rom_word[63:32];
      default: begin
        nxt_rdata = 32'h0000_0000;
        nxt_rresp = mrdb_pkg::RESP_SLVERR;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= mrdb_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= nxt_rdata;
      rresp <= nxt_rresp;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ========================================================
  // delta translator
  // only the sign-extended form is built here; the other translation
  // encodings live with the host transform logic
  logic inter_reg;
  logic xlat_active;
  logic [15:0] xlat_delta;
  logic [15:0] nxt_selector_delta;
  assign inter_reg = macro_instr[mrdb_pkg::OPC_HI:mrdb_pkg::OPC_LO] == mrdb_pkg::OPC_ZERO &&
    macro_instr[mrdb_pkg::SUBOP_HI:mrdb_pkg::SUBOP_LO] == mrdb_pkg::SUBOP_INTER_REG;
  assign xlat_active = !decimal_correction_flag && !file_route_flag && !inter_reg;
  assign xlat_delta = {{8{macro_instr[mrdb_pkg::DELTA_HI]}}, macro_instr[7:0]};
  always_comb begin
    if (file_route_flag) begin
      nxt_selector_delta = file_subop_data;
    end else if (inter_reg) begin
      nxt_selector_delta = mrdb_pkg::DELTA_ALL_ONES;
    end else if (xlat_active) begin
      nxt_selector_delta = xlat_delta;
    end else begin
      nxt_selector_delta = {8'h00, macro_instr[7:0]};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      selector_delta_ff <= 16'h0000;
    end else begin
      selector_delta_ff <= nxt_selector_delta;
    end
  end

  // ========================================================
  // micro memory and upper/lower selector
  logic [63:0] rom_out;
  assign rom_out = rom_word({micro_page_select, micro_word_addr});
  // the bus is released between reads so the x register can take other sources
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      x_bus_data_ff <= 32'h0000_0000;
      x_bus_oe_n_ff <= 1'b1;
    end else begin
      x_bus_oe_n_ff <= !micro_read_req;
      if (micro_read_req) begin
        x_bus_data_ff <= micro_upper_sel ? rom_out[63:32] : rom_out[31:0];
      end
    end
  end

  // ========================================================
  // bit test selector
  logic halt_sw_meta_ff;
  logic halt_sw_ff;
  logic pass_sw_meta_ff;
  logic pass_sw_ff;
  logic [15:0] bt_upper;
  logic [3:0] bt_sel;
  // panel switches are asynchronous to aclk
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      halt_sw_meta_ff <= 1'b0;
      halt_sw_ff <= 1'b0;
      pass_sw_meta_ff <= 1'b0;
      pass_sw_ff <= 1'b0;
    end else begin
      halt_sw_meta_ff <= selective_halt_switch;
      halt_sw_ff <= halt_sw_meta_ff;
      pass_sw_meta_ff <= selective_pass_switch;
      pass_sw_ff <= pass_sw_meta_ff;
    end
  end

  // one means take the upper instruction of the next pair
  assign bt_sel = micro_instr_reg[mrdb_pkg::BT_SEL_HI:0];
  assign bt_upper[0] = 1'b0;
  assign bt_upper[1] = macro_instr[13];
  assign bt_upper[2] = macro_instr[8];
  assign bt_upper[3] = macro_instr[9];
  assign bt_upper[4] = index_store_status;
  assign bt_upper[5] = !protect_fault_flag;
  assign bt_upper[6] = !halt_sw_ff;
  assign bt_upper[7] = !pass_sw_ff;
  assign bt_upper[8] = !parity_error_flag;
  assign bt_upper[9] = 1'b0;
  assign bt_upper[10] = macro_instr[7:0] == 8'h00;
  assign bt_upper[11] = !eff_addr_matches_operand;
  assign bt_upper[12] = even_parity_line;
  assign bt_upper[13] = macro_instr[15];
  assign bt_upper[14] = multilevel_indirect_mode;
  assign bt_upper[15] = protect_fault_flag || parity_error_flag;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bit_test_upper_ff <= 1'b0;
    end else begin
      bit_test_upper_ff <= test_field == mrdb_pkg::TEST_BIT_CMD && bt_upper[bt_sel];
    end
  end

  // ========================================================
  // decode-next-instruction sequencer
  mrdb_pkg::mrdb_seq_t nxt_seq;
  always_comb begin
    nxt_seq = seq_ff;
    unique case (seq_ff)
      mrdb_pkg::MRDB_SEQ_IDLE: begin
        if (ctrl_seq_en_ff && (emulation_done || kick_ff)) begin
          nxt_seq = mrdb_pkg::MRDB_SEQ_INC;
        end
      end
      mrdb_pkg::MRDB_SEQ_INC: nxt_seq = mrdb_pkg::MRDB_SEQ_READ;
      mrdb_pkg::MRDB_SEQ_READ: begin
        nxt_seq = interrupt_pending ? mrdb_pkg::MRDB_SEQ_INTR : mrdb_pkg::MRDB_SEQ_XFORM;
      end
      mrdb_pkg::MRDB_SEQ_XFORM: nxt_seq = mrdb_pkg::MRDB_SEQ_IDLE;
      mrdb_pkg::MRDB_SEQ_INTR: nxt_seq = mrdb_pkg::MRDB_SEQ_IDLE;
      default: nxt_seq = mrdb_pkg::MRDB_SEQ_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_ff <= mrdb_pkg::MRDB_SEQ_IDLE;
    end else begin
      seq_ff <= nxt_seq;
    end
  end

  // step strobes and entry address are registered copies of the next state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      increment_next_instr <= 1'b0;
      read_next_instr <= 1'b0;
      macro_fetch_transform <= 1'b0;
      interrupt_branch <= 1'b0;
      decode_entry_addr_ff <= mrdb_pkg::DECODE_LOC_A;
    end else begin
      increment_next_instr <= nxt_seq == mrdb_pkg::MRDB_SEQ_INC;
      read_next_instr <= nxt_seq == mrdb_pkg::MRDB_SEQ_READ;
      macro_fetch_transform <= nxt_seq == mrdb_pkg::MRDB_SEQ_XFORM;
      interrupt_branch <= nxt_seq == mrdb_pkg::MRDB_SEQ_INTR;
      decode_entry_addr_ff <= (nxt_seq == mrdb_pkg::MRDB_SEQ_INC ||
        nxt_seq == mrdb_pkg::MRDB_SEQ_READ) ? mrdb_pkg::DECODE_LOC_A
                                            : mrdb_pkg::DECODE_LOC_B;
    end
  end

  // ========================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_start;
    seq_ff == mrdb_pkg::MRDB_SEQ_IDLE && ctrl_seq_en_ff && emulation_done;
  endsequence
  sequence s_inc_read;
    increment_next_instr ##1 read_next_instr;
  endsequence
  a_irr_all_ones: assert property (inter_reg && !file_route_flag |=>
    selector_delta_ff == mrdb_pkg::DELTA_ALL_ONES) else $error("inter-register delta wrong");
  a_route_file: assert property (file_route_flag |=>
    selector_delta_ff == $past(file_subop_data)) else $error("file data not routed");
  a_xlat_used: assert property (xlat_active |=>
    selector_delta_ff == $past(xlat_delta)) else $error("translated delta missing");
  a_rom_to_xbus: assert property (micro_read_req |=> !x_bus_oe_n_ff &&
    x_bus_data_ff == ($past(micro_upper_sel) ? $past(rom_out[63:32]) : $past(rom_out[31:0])))
    else $error("x bus data wrong");
  a_decode_words: assert property (micro_read_req && micro_upper_sel &&
    {micro_page_select, micro_word_addr} == mrdb_pkg::DECODE_LOC_A |=>
    x_bus_data_ff == mrdb_pkg::UI_INCREMENT) else $error("decode routine missing");
  a_bt_no_cmd: assert property (test_field != mrdb_pkg::TEST_BIT_CMD |=>
    !bit_test_upper_ff) else $error("bit test without command");
  a_bt_unassigned: assert property (bt_sel == 4'h0 || bt_sel == 4'h9 |=>
    !bit_test_upper_ff) else $error("unassigned position selected upper");
  a_bt_delta_zero: assert property (test_field == mrdb_pkg::TEST_BIT_CMD &&
    bt_sel == 4'ha |=> bit_test_upper_ff == ($past(macro_instr[7:0]) == 8'h00))
    else $error("delta zero test wrong");
  a_bt_abort: assert property (test_field == mrdb_pkg::TEST_BIT_CMD && bt_sel == 4'hf &&
    (protect_fault_flag || parity_error_flag) |=> bit_test_upper_ff)
    else $error("aborted write test wrong");
  a_decode_order: assert property (s_start |=> s_inc_read ##1
    (macro_fetch_transform != interrupt_branch) &&
    (interrupt_branch == $past(interrupt_pending, 1))) else $error("decode order wrong");
endmodule // mrdb_top

// ==== test/mrdb_host_model.sv ====
/*
 host micro-sequencer model: ends emulations and reads the micro memory.
 assumes it shares aclk with the block and changes its outputs at rising edges.
*/
module mrdb_host_model (
  // clock
  input wire logic aclk,
  // sequencing
  output logic emulation_done,
  // micro memory read
  output logic micro_read_req,
  output logic [7:0] micro_word_addr,
  output logic micro_page_select,
  output logic micro_upper_sel,
  // three-state bus
  input wire logic [31:0] x_bus_data_ff,
  input wire logic x_bus_oe_n_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] bus_seen;
  // ==========================================================
  // bus level
  // a released bus shows the inverse, so a stale word can never pass
  assign bus_seen = x_bus_oe_n_ff ? ~x_bus_data_ff : x_bus_data_ff;
  initial begin
    emulation_done = 1'b0;
    micro_read_req = 1'b0;
    micro_word_addr = 8'h00;
    micro_page_select = 1'b0;
    micro_upper_sel = 1'b0;
  end
  // ==========================================================
  // requests
  task automatic end_emulation();
    @(posedge aclk);
    emulation_done <= 1'b1;
    @(posedge aclk);
    emulation_done <= 1'b0;
  endtask
  // word taken the cycle after the request, release checked one cycle later
  task automatic read_micro(input logic [8:0] a, input logic up, output logic [31:0] d,
                            output logic oe_n);
    @(posedge aclk);
    micro_read_req <= 1'b1;
    micro_word_addr <= a[7:0];
    micro_page_select <= a[8];
    micro_upper_sel <= up;
    @(posedge aclk);
    micro_read_req <= 1'b0;
    @(negedge aclk);
    d = bus_seen;
    @(negedge aclk);
    oe_n = x_bus_oe_n_ff;
  endtask
endmodule // mrdb_host_model

// ==== test/test_microcode_rom_delta_bittest.sv ====
/*
 self-checking bench for the micro memory, delta translator and bit test block.
 assumes the host model issues emulation ends and micro reads; the bench drives the rest.
*/
module test_microcode_rom_delta_bittest;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // signals
  logic aclk = 1'b0, aresetn = 1'b0;
  int bad_count = 0, tests_run = 0, inc_count = 0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, micro_instr_reg = 32'h0, rdata, x_bus_data_ff;
  logic [3:0] wstrb = 4'h0, test_field = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, x_bus_oe_n_ff, bit_test_upper_ff;
  logic [1:0] bresp, rresp;
  logic [15:0] macro_instr = 16'h0001, file_subop_data = 16'ha5c3, selector_delta_ff;
  logic decimal_correction_flag = 1'b0, file_route_flag = 1'b0, interrupt_pending = 1'b0;
  logic index_store_status = 1'b0, protect_fault_flag = 1'b0, parity_error_flag = 1'b0;
  logic selective_halt_switch = 1'b0, selective_pass_switch = 1'b0;
  logic eff_addr_matches_operand = 1'b0, even_parity_line = 1'b0;
  logic multilevel_indirect_mode = 1'b0, micro_read_req, micro_page_select, micro_upper_sel;
  logic emulation_done, increment_next_instr, read_next_instr, macro_fetch_transform;
  logic interrupt_branch;
  logic [7:0] micro_word_addr;
  logic [8:0] decode_entry_addr_ff;
  logic [12:0] seq_vec;
  assign seq_vec = {increment_next_instr, read_next_instr, macro_fetch_transform,
                    interrupt_branch, decode_entry_addr_ff};
  initial forever #4 aclk = ~aclk;
  always @(posedge aclk) if (increment_next_instr === 1'b1) inc_count++;
  mrdb_top DUT (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
    .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
    .rresp, .macro_instr, .file_subop_data, .decimal_correction_flag, .file_route_flag,
    .selector_delta_ff, .micro_read_req, .micro_word_addr, .micro_page_select,
    .micro_upper_sel, .x_bus_data_ff, .x_bus_oe_n_ff, .micro_instr_reg, .test_field,
    .index_store_status, .protect_fault_flag, .parity_error_flag, .selective_halt_switch,
    .selective_pass_switch, .eff_addr_matches_operand, .even_parity_line,
    .multilevel_indirect_mode, .bit_test_upper_ff, .emulation_done, .interrupt_pending,
    .decode_entry_addr_ff, .increment_next_instr, .read_next_instr, .macro_fetch_transform,
    .interrupt_branch);
  mrdb_host_model host (.aclk, .emulation_done, .micro_read_req, .micro_word_addr,
    .micro_page_select, .micro_upper_sel, .x_bus_data_ff, .x_bus_oe_n_ff);
  // ==========================================================
  // shared tasks
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic timed_out(input string what);
    bad_count++;
    $display("[ERR] %s expected handshake seen none", what);
    complete_run();
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask
  // handshakes are judged mid-cycle, where the comb readies have settled
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic aw_hs, w_hs, b_hs;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      aw_hs = awvalid && awready;
      w_hs = wvalid && wready;
      b_hs = bvalid && bready;
      r = bresp;
      @(posedge aclk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
      if (b_hs) bready <= 1'b0;
      if (b_hs) break;
    end
    if (n == 50) timed_out("axi write");
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ar_hs, r_hs;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      ar_hs = arvalid && arready;
      r_hs = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ar_hs) arvalid <= 1'b0;
      if (r_hs) rready <= 1'b0;
      if (r_hs) break;
    end
    if (n == 50) timed_out("axi read");
  endtask
  // ==========================================================
  // scenarios
  task automatic delta_one(input logic [15:0] mi, input logic dec, input logic rt,
                           input logic [15:0] exp);
    @(posedge aclk);
    macro_instr <= mi;
    decimal_correction_flag <= dec;
    file_route_flag <= rt;
    settle(1);
    chk("selector_delta", exp, selector_delta_ff);
  endtask
  task automatic delta_cases();
    delta_one(16'h0885, 1'b0, 1'b0, 16'hffff);
    delta_one(16'h0885, 1'b0, 1'b1, 16'ha5c3);
    delta_one(16'h0185, 1'b0, 1'b1, 16'ha5c3);
    delta_one(16'h0185, 1'b0, 1'b0, 16'hff85);
    delta_one(16'h0185, 1'b1, 1'b0, 16'h0085);
    delta_one(16'h1842, 1'b0, 1'b0, 16'h0042);
  endtask
  task automatic micro_one(input logic [8:0] a, input logic up, input logic [31:0] exp);
    logic [31:0] d;
    logic oe_n;
    host.read_micro(a, up, d, oe_n);
    chk("x_bus word and release", {1'b1, exp}, {oe_n, d});
  endtask
  task automatic micro_reads();
    micro_one(9'h058, 1'b1, mrdb_pkg::UI_INCREMENT);
    micro_one(9'h058, 1'b0, mrdb_pkg::UI_READ_NEXT);
    micro_one(9'h059, 1'b1, mrdb_pkg::UI_INT_BRANCH);
    micro_one(9'h059, 1'b0, mrdb_pkg::UI_FETCH_XFORM);
    micro_one(9'h1ff, 1'b0, {2{16'h01ff}});
    micro_one(9'h100, 1'b1, {2{16'h0100}});
  endtask
  // switches pass a two-stage synchroniser, so every case waits three cycles
  task automatic bit_test_scan();
    int p, c;
    logic e;
    for (p = 0; p < 16; p++) begin
      for (c = 0; c < 2; c++) begin
        @(posedge aclk);
        test_field <= mrdb_pkg::TEST_BIT_CMD;
        micro_instr_reg <= {28'h0000000, 4'(p)};
        macro_instr <= {c == 1 && p == 13, 1'b0, c == 1 && p == 1, 3'h0, c == 1 && p == 3,
                        c == 1 && p == 2, 7'h00, !(c == 1 && p == 10)};
        index_store_status <= c == 1 && p == 4;
        protect_fault_flag <= c == 1 && (p == 5 || p == 15);
        parity_error_flag <= c == 1 && p == 8;
        selective_halt_switch <= c == 1 && p == 6;
        selective_pass_switch <= c == 1 && p == 7;
        eff_addr_matches_operand <= c == 1 && p == 11;
        even_parity_line <= c == 1 && p == 12;
        multilevel_indirect_mode <= c == 1 && p == 14;
        e = (p inside {5, 6, 7, 8, 11}) ? c == 0 : c == 1;
        if (p == 0 || p == 9) e = 1'b0;
        settle(3);
        chk("bit_test_upper", e, bit_test_upper_ff);
      end
    end
    @(posedge aclk);
    micro_instr_reg <= 32'hffffffff;
    settle(3);
    chk("bit_test upper instr bits", 1'b1, bit_test_upper_ff);
    @(posedge aclk);
    test_field <= 4'h4;
    settle(3);
    chk("bit_test without command", 1'b0, bit_test_upper_ff);
  endtask
  task automatic seq_case(input logic intr);
    @(posedge aclk);
    interrupt_pending <= intr;
    host.end_emulation();
    @(negedge aclk);
    chk("seq increment", {4'b1000, mrdb_pkg::DECODE_LOC_A}, seq_vec);
    @(negedge aclk);
    chk("seq read", {4'b0100, mrdb_pkg::DECODE_LOC_A}, seq_vec);
    @(negedge aclk);
    chk("seq branch", {2'b00, !intr, intr, mrdb_pkg::DECODE_LOC_B}, seq_vec);
  endtask
  task automatic reg_access();
    logic [31:0] d;
    logic [1:0] r;
    int n0;
    axi_read(mrdb_pkg::ADDR_CTRL, d, r);
    chk("ctrl reset", {2'h0, 32'h1}, {r, d});
    axi_write(mrdb_pkg::ADDR_ROM_ADDR, 32'h059, r);
    axi_read(mrdb_pkg::ADDR_ROM_LO, d, r);
    chk("rom lo", {2'h0, mrdb_pkg::UI_FETCH_XFORM}, {r, d});
    axi_read(mrdb_pkg::ADDR_ROM_HI, d, r);
    chk("rom hi", {2'h0, mrdb_pkg::UI_INT_BRANCH}, {r, d});
    axi_write(mrdb_pkg::ADDR_ROM_ADDR, 32'h1a3, r);
    axi_read(mrdb_pkg::ADDR_ROM_HI, d, r);
    chk("rom page 1", {2'h0, {2{16'h01a3}}}, {r, d});
    axi_read(8'h40, d, r);
    chk("unmapped read", {mrdb_pkg::RESP_SLVERR, 32'h0}, {r, d});
    axi_write(8'h40, 32'h1, r);
    chk("unmapped write", mrdb_pkg::RESP_SLVERR, r);
    axi_write(mrdb_pkg::ADDR_CTRL, 32'h0, r);
    n0 = inc_count;
    host.end_emulation();
    settle(4);
    chk("disabled sequencer", n0, inc_count);
    axi_write(mrdb_pkg::ADDR_CTRL, 32'h3, r);
    settle(5);
    chk("kicked sequencer", n0 + 1, inc_count);
    axi_read(mrdb_pkg::ADDR_STATUS, d, r);
    chk("status", 5'b11000, {d[10:9], d[2:0]});
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (12) @(posedge aclk);
    @(negedge aclk);
    chk("reset values", {16'h0, 1'b1, 1'b0, 9'h058, 2'b00},
        {selector_delta_ff, x_bus_oe_n_ff, bit_test_upper_ff, decode_entry_addr_ff, bvalid,
         rvalid});
    @(posedge aclk);
    aresetn <= 1'b1;
    delta_cases();
    micro_reads();
    bit_test_scan();
    seq_case(1'b0);
    seq_case(1'b1);
    reg_access();
    complete_run();
  end
endmodule // test_microcode_rom_delta_bittest
